/* File: rtl/rcdr_top.sv */
`default_nettype none

module rcdr_top (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // Write address channel
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // Write data channel
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // Write response channel
    output logic      [1:0]  s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // Read address channel
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // Read data channel
    output logic      [31:0] s_axi_rdata,
    output logic      [1:0]  s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Date and lock state
    output logic      [31:0] calendar_date_word,
    output logic             clock_write_unlock
);

    // Bus slave state
    typedef struct packed {
        logic        aw_full;
        logic [7:0]  aw_addr;
        logic        w_full;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } rcdr_axi_s;

    rcdr_axi_s st;
    rcdr_axi_s next_st;

    logic        wr_fire;
    logic        ctrl_wr;
    logic        date_wr;
    logic        wr_mapped;
    logic        rd_take;
    logic        rd_mapped;
    logic [31:0] rd_word;
    logic [31:0] ctrl_word;
    logic [31:0] date_word;
    logic [31:0] stat_word;
    logic        date_legal;
    logic        unlock;

    // Protection bits carry no meaning here
    logic        prot_unused;
    assign prot_unused = ^{s_axi_awprot, s_axi_arprot};

    // Address and data are held until both are present
    assign s_axi_awready = !st.aw_full;
    assign s_axi_wready  = !st.w_full;
    assign s_axi_arready = !st.rvalid;

    // A write commits once both halves are in and no answer is pending
    assign wr_fire   = st.aw_full && st.w_full && !st.bvalid;
    assign ctrl_wr   = wr_fire && rcdr_pkg::is_reg(st.aw_addr, rcdr_pkg::CTRL_OFFSET);
    assign date_wr   = wr_fire && rcdr_pkg::is_reg(st.aw_addr, rcdr_pkg::DATE_OFFSET);
    assign wr_mapped = rcdr_pkg::is_reg(st.aw_addr, rcdr_pkg::CTRL_OFFSET)
                    || rcdr_pkg::is_reg(st.aw_addr, rcdr_pkg::DATE_OFFSET)
                    || rcdr_pkg::is_reg(st.aw_addr, rcdr_pkg::STAT_OFFSET);

    assign rd_take   = s_axi_arvalid && !st.rvalid;
    assign rd_mapped = rcdr_pkg::is_reg(s_axi_araddr, rcdr_pkg::CTRL_OFFSET)
                    || rcdr_pkg::is_reg(s_axi_araddr, rcdr_pkg::DATE_OFFSET)
                    || rcdr_pkg::is_reg(s_axi_araddr, rcdr_pkg::STAT_OFFSET);

    // Status word shows lock state and digit legality
    always_comb begin
        stat_word = 32'h00000000;
        stat_word[rcdr_pkg::STAT_UNLOCK_BIT] = unlock;
        stat_word[rcdr_pkg::STAT_LEGAL_BIT]  = date_legal;
    end

    // Read mux; unmapped reads return zero
    always_comb begin
        rd_word = 32'h00000000;
        if (rcdr_pkg::is_reg(s_axi_araddr, rcdr_pkg::CTRL_OFFSET)) begin
            rd_word = ctrl_word;
        end else if (rcdr_pkg::is_reg(s_axi_araddr, rcdr_pkg::DATE_OFFSET)) begin
            rd_word = date_word;
        end else if (rcdr_pkg::is_reg(s_axi_araddr, rcdr_pkg::STAT_OFFSET)) begin
            rd_word = stat_word;
        end
    end

    // Channel bookkeeping
    always_comb begin
        next_st = st;
        // Capture write address
        if (s_axi_awvalid && !st.aw_full) begin
            next_st.aw_full = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        // Capture write data
        if (s_axi_wvalid && !st.w_full) begin
            next_st.w_full = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end
        // Retire response before a new commit can raise it again
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        // Commit; a locked date write still answers OKAY, silently
        if (wr_fire) begin
            next_st.aw_full = 1'b0;
            next_st.w_full  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = wr_mapped ? rcdr_pkg::RESP_OKAY : rcdr_pkg::RESP_SLVERR;
        end
        // Read answer
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (rd_take) begin
            next_st.rvalid = 1'b1;
            next_st.rdata  = rd_word;
            next_st.rresp  = rd_mapped ? rcdr_pkg::RESP_OKAY : rcdr_pkg::RESP_SLVERR;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp  = st.bresp;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata  = st.rdata;
    assign s_axi_rresp  = st.rresp;

    // Control word holding the unlock bit
    rcdr_unlock_ctl u_unlock (
        .clk_sys            (clk_sys),
        .reset_n            (reset_n),
        .wr_en              (ctrl_wr),
        .wr_data            (st.w_data),
        .wr_strb            (st.w_strb),
        .clock_control_word (ctrl_word),
        .clock_write_unlock (unlock)
    );

    // Date store; unlock sampled in the commit cycle
    // gated by unlock
    rcdr_date_store u_date (
        .clk_sys            (clk_sys),
        .reset_n            (reset_n),
        .wr_en              (date_wr),
        .wr_data            (st.w_data),
        .wr_strb            (st.w_strb),
        .clock_write_unlock (unlock),
        .calendar_date_word (date_word),
        .date_is_legal      (date_legal)
    );

    assign calendar_date_word = date_word;
    assign clock_write_unlock = unlock;

endmodule // rcdr_top

`default_nettype wire

/* File: rtl/rcdr_pkg.sv */
`default_nettype none

package rcdr_pkg;

    // Bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned STRB_W = 4;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] DATE_OFFSET = 8'h04;
    localparam logic [7:0] STAT_OFFSET = 8'h08;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Date word field positions (low bit of each field)
    localparam int unsigned YEAR_TENS_LSB   = 28;
    localparam int unsigned YEAR_UNITS_LSB  = 24;
    localparam int unsigned MONTH_TENS_LSB  = 20;
    localparam int unsigned MONTH_UNITS_LSB = 16;
    localparam int unsigned DAY_TENS_LSB    = 12;
    localparam int unsigned DAY_UNITS_LSB   = 8;
    localparam int unsigned WEEKDAY_LSB     = 0;

    // Largest legal digit values
    localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
    localparam logic [2:0] WEEKDAY_MAX   = 3'h6;

    // Implemented bits; all others read as zero
    localparam logic [31:0] DATE_IMPL_MASK = 32'hff1f3f07;
    localparam logic [31:0] CTRL_IMPL_MASK = 32'h00000008;

    // Reset values
    localparam logic [31:0] DATE_RESET = 32'h00000000;
    localparam logic [31:0] CTRL_RESET = 32'h00000000;

    // Control and status bit positions
    localparam int unsigned CTRL_UNLOCK_BIT = 3;
    localparam int unsigned STAT_UNLOCK_BIT = 0;
    localparam int unsigned STAT_LEGAL_BIT  = 1;

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge_strb(
        input logic [31:0] old_word,
        input logic [31:0] new_word,
        input logic [3:0]  strb
    );
        logic [31:0] result;
        result = old_word;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                result[i*8 +: 8] = new_word[i*8 +: 8];
            end
        end
        return result;
    endfunction

    // Word decode; the low two address bits are ignored
    function automatic logic is_reg(
        input logic [7:0] addr,
        input logic [7:0] offset
    );
        return addr[7:2] == offset[7:2];
    endfunction

    // Year digits, month and day units digits, and the weekday within their legal range
    function automatic logic date_legal(input logic [31:0] word);
        return (word[YEAR_TENS_LSB +: 4] <= BCD_DIGIT_MAX)
            && (word[YEAR_UNITS_LSB +: 4] <= BCD_DIGIT_MAX)
            && (word[MONTH_UNITS_LSB +: 4] <= BCD_DIGIT_MAX)
            && (word[DAY_UNITS_LSB +: 4] <= BCD_DIGIT_MAX)
            && (word[WEEKDAY_LSB +: 3] <= WEEKDAY_MAX);
    endfunction

endpackage

`default_nettype wire

/* File: rtl/rcdr_unlock_ctl.sv */
`default_nettype none

module rcdr_unlock_ctl (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // Register write
    input  wire logic        wr_en,
    input  wire logic [31:0] wr_data,
    input  wire logic [3:0]  wr_strb,
    // State
    output logic      [31:0] clock_control_word,
    output logic             clock_write_unlock
);

    typedef struct packed {
        logic [31:0] ctrl;
    } rcdr_ctl_s;

    rcdr_ctl_s st;
    rcdr_ctl_s next_st;

    // Control word, only the unlock bit is kept
    always_comb begin
        next_st = st;
        if (wr_en) begin
            next_st.ctrl = rcdr_pkg::merge_strb(st.ctrl, wr_data, wr_strb)
                         & rcdr_pkg::CTRL_IMPL_MASK;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st.ctrl <= rcdr_pkg::CTRL_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign clock_control_word = st.ctrl;
    assign clock_write_unlock = st.ctrl[rcdr_pkg::CTRL_UNLOCK_BIT];

endmodule // rcdr_unlock_ctl

`default_nettype wire

/* File: rtl/rcdr_date_store.sv */
`default_nettype none

module rcdr_date_store (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // Register write
    input  wire logic        wr_en,
    input  wire logic [31:0] wr_data,
    input  wire logic [3:0]  wr_strb,
    input  wire logic        clock_write_unlock,
    // State
    output logic      [31:0] calendar_date_word,
    output logic             date_is_legal
);

    typedef struct packed {
        logic [31:0] date;
    } rcdr_date_s;

    rcdr_date_s st;
    rcdr_date_s next_st;

    // Write gate on the unlock bit
    always_comb begin
        next_st = st;
        if (wr_en && clock_write_unlock) begin
            next_st.date = rcdr_pkg::merge_strb(st.date, wr_data, wr_strb)
                         & rcdr_pkg::DATE_IMPL_MASK;
        end
    end

    // Fields are undefined on a real part; zero here for a clean start
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st.date <= rcdr_pkg::DATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign calendar_date_word = st.date;
    assign date_is_legal      = rcdr_pkg::date_legal(st.date);

endmodule // rcdr_date_store

`default_nettype wire

/* File: sim/rcdr_top_sva.sv */
`default_nettype none

module rcdr_top_sva (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        reset_n,
    // Bus handshakes
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Date and lock state
    input wire logic [31:0] calendar_date_word,
    input wire logic        clock_write_unlock
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    a_unused_bits_zero: assert property ((calendar_date_word & 32'h00e0c0f8) == 32'h0)
        else $error("date word unused bits set");
    a_date_readback: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr[7:2] == 6'h01 |=> s_axi_rdata == $past(calendar_date_word))
        else $error("date read does not match stored word");
    a_locked_date_hold: assert property (!clock_write_unlock |=> $stable(calendar_date_word))
        else $error("date changed while locked");
    a_date_change_cause: assert property ($changed(calendar_date_word)
        |-> $rose(s_axi_bvalid) && $past(clock_write_unlock))
        else $error("date changed outside an unlocked write");
    a_unlock_cause: assert property ($changed(clock_write_unlock) |-> $rose(s_axi_bvalid))
        else $error("unlock bit changed outside a write");
    // Answer two edges after the take, as handed over
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready && !s_axi_bvalid |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response late or early");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer not one cycle after take");
endmodule // rcdr_top_sva

bind rcdr_top rcdr_top_sva u_sva (
    .clk_sys            (clk_sys),
    .reset_n            (reset_n),
    .s_axi_araddr       (s_axi_araddr),
    .s_axi_awvalid      (s_axi_awvalid),
    .s_axi_awready      (s_axi_awready),
    .s_axi_wvalid       (s_axi_wvalid),
    .s_axi_wready       (s_axi_wready),
    .s_axi_bresp        (s_axi_bresp),
    .s_axi_bvalid       (s_axi_bvalid),
    .s_axi_bready       (s_axi_bready),
    .s_axi_arvalid      (s_axi_arvalid),
    .s_axi_arready      (s_axi_arready),
    .s_axi_rdata        (s_axi_rdata),
    .s_axi_rvalid       (s_axi_rvalid),
    .s_axi_rready       (s_axi_rready),
    .calendar_date_word (calendar_date_word),
    .clock_write_unlock (clock_write_unlock)
);

`default_nettype wire

/* File: sim/rcdr_top_test.sv */
`default_nettype none

module rcdr_top_test;
    timeunit 1ns;
    timeprecision 1ns;

    // Bench-driven inputs, all set at time zero
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    // Design outputs
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        clock_write_unlock;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, calendar_date_word;
    int          fails = 0;
    int          num_checks = 0;

    localparam logic [1:0] OK = rcdr_pkg::RESP_OKAY;
    localparam logic [1:0] ER = rcdr_pkg::RESP_SLVERR;
    // Top legal value of each field alone, then every bit set
    localparam logic [31:0] FLD [8] = '{32'h90000000, 32'h09000000, 32'h00100000,
        32'h00090000, 32'h00003000, 32'h00000900, 32'h00000006, 32'hffffffff};

    // Protection inputs carry no behaviour here, so they are tied
    rcdr_top uut (
        .clk_sys            (clk_sys),
        .reset_n            (reset_n),
        .s_axi_awaddr       (s_axi_awaddr),
        .s_axi_awprot       (3'h0),
        .s_axi_awvalid      (s_axi_awvalid),
        .s_axi_awready      (s_axi_awready),
        .s_axi_wdata        (s_axi_wdata),
        .s_axi_wstrb        (s_axi_wstrb),
        .s_axi_wvalid       (s_axi_wvalid),
        .s_axi_wready       (s_axi_wready),
        .s_axi_bresp        (s_axi_bresp),
        .s_axi_bvalid       (s_axi_bvalid),
        .s_axi_bready       (s_axi_bready),
        .s_axi_araddr       (s_axi_araddr),
        .s_axi_arprot       (3'h0),
        .s_axi_arvalid      (s_axi_arvalid),
        .s_axi_arready      (s_axi_arready),
        .s_axi_rdata        (s_axi_rdata),
        .s_axi_rresp        (s_axi_rresp),
        .s_axi_rvalid       (s_axi_rvalid),
        .s_axi_rready       (s_axi_rready),
        .calendar_date_word (calendar_date_word),
        .clock_write_unlock (clock_write_unlock)
    );

    always #50 clk_sys = ~clk_sys;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict(input logic hung);
        if (hung) chk(32'h1, 32'h0);
        if (fails == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Ready is raised only once the answer shows, so the slave sees a stall
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        int   n;
        logic aw, w;
        n = 0;
        aw = 1'b1;
        w = 1'b1;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (n > 40) print_verdict(1'b1);
            if (aw && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (w && s_axi_wready) s_axi_wvalid <= 1'b0;
            aw = aw && !s_axi_awready;
            w = w && !s_axi_wready;
            // Raise once only, so the release below is the sole drive at the taking edge
            if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (n > 40) print_verdict(1'b1);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, ed);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd(8'h04, 32'h0, OK);
        chk({31'h0, clock_write_unlock}, 32'h0);
        wr(8'h04, 32'h12345678, 4'hf, OK);
        rd(8'h04, 32'h0, OK);
        wr(8'h00, 32'hffffffff, 4'hf, OK);
        rd(8'h00, 32'h8, OK);
        chk({31'h0, clock_write_unlock}, 32'h1);
        foreach (FLD[i]) begin
            wr(8'h04, FLD[i], 4'hf, OK);
            rd(8'h04, FLD[i] & 32'hff1f3f07, OK);
            chk(calendar_date_word, FLD[i] & 32'hff1f3f07);
        end
        // Single lane write keeps the other bytes
        wr(8'h04, 32'h00000500, 4'h2, OK);
        rd(8'h04, 32'hff1f0507, OK);
        rd(8'h08, 32'h1, OK);
        wr(8'h04, 32'h25123106, 4'hf, OK);
        wr(8'h08, 32'h0, 4'hf, OK);
        rd(8'h08, 32'h3, OK);
        // Unmapped place refuses and changes nothing
        wr(8'h0c, 32'h0, 4'hf, ER);
        rd(8'h0c, 32'h0, ER);
        // Relock, then a date write must be lost
        wr(8'h00, 32'h0, 4'hf, OK);
        chk({31'h0, clock_write_unlock}, 32'h0);
        wr(8'h04, 32'h0, 4'hf, OK);
        rd(8'h04, 32'h25123106, OK);
        chk(calendar_date_word, 32'h25123106);
        print_verdict(1'b0);
    end
endmodule // rcdr_top_test

`default_nettype wire
